// *** fpd_consts.svh ***
`ifndef FPD_CONSTS_SVH
`define FPD_CONSTS_SVH
// Notes on behaviour
// - Host pipeline has eight stages; plain instructions pass unchanged.
// - Second decode stage classifies float; float ops get one extra decode.
// - Float memory read sits at host second read stage; read waits stall.
// - Float first execute and write align with host; write waits stall.
// - Math and conversion use a second execute stage, one cycle later.
// - Two-cycle ops issue every cycle; result valid one cycle late.
// - Add, subtract, multiply and multiply-accumulate are two-cycle ops.
// - Integer/float conversions, rounding too, are two-cycle ops.
// - Load, store, compare, min, max, abs, negate finish in one cycle.
// - Single-repeat multiply-accumulate needs no alignment; others two-cycle.
// - Core-to-float register moves take their own alignment path.
// - Eight 32-bit float result registers exist.
// - A 32-bit float status and 32-bit repeat-block register exist.
// - Result and status registers each have a shadow copy.
// - Save copies into shadows for non-nesting handlers; restore copies back.
`define FPD_NUM_REGS 8
`define FPD_DATA_W 32
`define FPD_IDX_W 3
`define FPD_OP_W 4
// Float opcode encodings
`define FPD_OP_NONE 4'h0
`define FPD_OP_LOAD 4'h1
`define FPD_OP_STORE 4'h2
`define FPD_OP_CMP 4'h3
`define FPD_OP_MINMAX 4'h4
`define FPD_OP_ABSNEG 4'h5
`define FPD_OP_ADD 4'h6
`define FPD_OP_SUB 4'h7
`define FPD_OP_MUL 4'h8
`define FPD_OP_MAC 4'h9
`define FPD_OP_MAC_RPT 4'ha
`define FPD_OP_CVT 4'hb
`define FPD_OP_TO_CORE 4'hc
`define FPD_OP_FROM_CORE 4'hd
`define FPD_OP_SAVE 4'he
`define FPD_OP_RESTORE 4'hf
`define FPD_STF_RST 32'h0000_0000
`define FPD_RB_RST 32'h0000_0000
`endif

// *** fpd_pkg.sv ***
package fpd_pkg;
  typedef logic [31:0] fpd_word_t;
  typedef logic [3:0] fpd_op_t;
  // Pipeline slot travelling beside the host stages
  typedef struct packed {
    logic vld;
    fpd_op_t op;
    logic [2:0] dst;
    fpd_word_t val;
  } fpd_slot_s;
  typedef struct packed {
    fpd_slot_s fdec;
    fpd_slot_s rd;
    fpd_slot_s ex1;
    fpd_slot_s ex2;
    fpd_word_t [7:0] res;
    fpd_word_t [7:0] shd;
    fpd_word_t float_status_reg;
    fpd_word_t stf_shd;
    fpd_word_t rb;
    fpd_word_t core_out;
    logic core_vld;
  } fpd_state_s;
endpackage

// *** fpd_pipe.sv ***
`timescale 1ns/100ps
`include "fpd_consts.svh"
module fpd_pipe
  import fpd_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_rstn,
  input wire logic i_d2_vld,
  input wire logic i_d2_is_float,
  input wire logic [3:0] i_d2_op,
  input wire logic [2:0] i_d2_dst,
  input wire logic i_rd_wait,
  input wire logic i_wr_wait,
  input wire logic [31:0] i_rd_data,
  input wire logic [31:0] i_exec_result,
  input wire logic [31:0] i_core_data,
  input wire logic i_rb_we,
  input wire logic [31:0] i_rb_wdata,
  input wire logic i_stf_we,
  input wire logic [31:0] i_stf_wdata,
  input wire logic [2:0] i_rd_idx,
  output logic o_stall,
  output logic [31:0] o_rd_value,
  output logic [31:0] o_core_data,
  output logic o_core_vld,
  output logic [31:0] o_stf,
  output logic [31:0] o_rb,
  output logic o_ex2_busy
);
  // ************************************************************
  // Classification helpers
  // ************************************************************
  // Ops needing the second execute stage
  function automatic logic is_two_cycle(input fpd_op_t op);
    is_two_cycle = (op == `FPD_OP_ADD) || (op == `FPD_OP_SUB)
      || (op == `FPD_OP_MUL) || (op == `FPD_OP_MAC)
      || (op == `FPD_OP_CVT);
  endfunction

  // Ops that write a result register
  function automatic logic writes_res(input fpd_op_t op);
    writes_res = (op == `FPD_OP_LOAD) || (op == `FPD_OP_MINMAX)
      || (op == `FPD_OP_ABSNEG) || (op == `FPD_OP_FROM_CORE)
      || (op == `FPD_OP_MAC_RPT) || is_two_cycle(op);
  endfunction

  fpd_state_s st_r;
  fpd_state_s st_nxt;
  logic stall;
  logic ex1_two;

  // Memory waits freeze every float stage except second execute, which still retires
  assign stall = i_rd_wait | i_wr_wait;

  // Two-cycle op leaving first execute on this edge
  assign ex1_two = st_r.ex1.vld && is_two_cycle(st_r.ex1.op) && !stall;

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.core_vld = 1'b0;
    // Host-side writes to repeat-block and status
    if (i_rb_we)
    begin
      st_nxt.rb = i_rb_wdata;
    end
    if (i_stf_we)
    begin
      st_nxt.float_status_reg = i_stf_wdata;
    end
    // Second execute retires one cycle after host execute
    if (st_r.ex2.vld)
    begin
      st_nxt.res[st_r.ex2.dst] = st_r.ex2.val;
    end
    st_nxt.ex2.vld = 1'b0;
    if (!stall)
    begin
      // First execute stage, aligned with host execute/write
      if (st_r.ex1.vld)
      begin
        if (is_two_cycle(st_r.ex1.op))
        begin
          st_nxt.ex2 = st_r.ex1;
          st_nxt.ex2.val = i_exec_result;
        end
        else if (st_r.ex1.op == `FPD_OP_SAVE)
        begin
          st_nxt.shd = st_r.res;
          st_nxt.stf_shd = st_r.float_status_reg;
        end
        else if (st_r.ex1.op == `FPD_OP_RESTORE)
        begin
          st_nxt.res = st_r.shd;
          st_nxt.float_status_reg = st_r.stf_shd;
        end
        else if (st_r.ex1.op == `FPD_OP_TO_CORE)
        begin
          st_nxt.core_out = st_r.res[st_r.ex1.dst];
          st_nxt.core_vld = 1'b1;
        end
        else if (st_r.ex1.op == `FPD_OP_FROM_CORE)
        begin
          st_nxt.res[st_r.ex1.dst] = st_r.ex1.val;
        end
        else if (st_r.ex1.op == `FPD_OP_LOAD)
        begin
          st_nxt.res[st_r.ex1.dst] = st_r.ex1.val;
        end
        else if (writes_res(st_r.ex1.op))
        begin
          st_nxt.res[st_r.ex1.dst] = i_exec_result;
        end
      end
      // Read stage aligned with host second read stage
      st_nxt.ex1 = st_r.rd;
      if (st_r.rd.op == `FPD_OP_FROM_CORE)
      begin
        st_nxt.ex1.val = i_core_data;
      end
      else
      begin
        st_nxt.ex1.val = i_rd_data;
      end
      // Extra float decode stage
      st_nxt.rd = st_r.fdec;
      // Second decode classifies; plain instructions never enter
      st_nxt.fdec.vld = i_d2_vld & i_d2_is_float;
      st_nxt.fdec.op = i_d2_op;
      st_nxt.fdec.dst = i_d2_dst;
      st_nxt.fdec.val = '0;
    end
    // Hazards are not checked; software fills the delay slot
  end

  // ************************************************************
  // State register
  // ************************************************************
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rstn)
    begin
      st_r <= '0;
      st_r.float_status_reg <= `FPD_STF_RST;
      st_r.rb <= `FPD_RB_RST;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign o_stall = stall;
  assign o_rd_value = st_r.res[i_rd_idx];
  assign o_core_data = st_r.core_out;
  assign o_core_vld = st_r.core_vld;
  assign o_stf = st_r.float_status_reg;
  assign o_rb = st_r.rb;
  assign o_ex2_busy = st_r.ex2.vld;

  // ************************************************************
  // Checks
  // ************************************************************
  sequence two_cycle_in_ex1;
    ex1_two;
  endsequence

  ex2_follow_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    two_cycle_in_ex1 |=> o_ex2_busy)
    else $error("second execute not entered");
  ex2_retire_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    st_r.ex2.vld |=> !st_r.ex2.vld || $past(ex1_two))
    else $error("second execute held too long");
  ex2_write_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    (st_r.ex2.vld && i_rstn) |=> st_r.res[$past(st_r.ex2.dst)] == $past(st_r.ex2.val)
      || $past(ex1_two))
    else $error("result not written");
  float_decode_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    (i_d2_vld && i_d2_is_float && !stall) |=> st_r.fdec.vld)
    else $error("float decode slot missing");
  plain_skip_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    (!i_d2_is_float && !stall) |=> !st_r.fdec.vld)
    else $error("plain instruction entered float pipe");
  stall_hold_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    stall |=> $stable(st_r.ex1) && $stable(st_r.rd))
    else $error("stage moved during wait");
  single_no_ex2_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    (st_r.ex1.vld && !is_two_cycle(st_r.ex1.op) && !stall) |=> !o_ex2_busy)
    else $error("single-cycle op used second execute");
  rpt_mac_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    (st_r.ex1.vld && st_r.ex1.op == `FPD_OP_MAC_RPT && !stall) |=> !o_ex2_busy)
    else $error("repeat mac took extra stage");
  save_shadow_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    (st_r.ex1.vld && st_r.ex1.op == `FPD_OP_SAVE && !stall && !st_r.ex2.vld)
      |=> st_r.shd == $past(st_r.res))
    else $error("shadow copy missing");
  core_move_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    (st_r.ex1.vld && st_r.ex1.op == `FPD_OP_TO_CORE && !stall) |=> o_core_vld)
    else $error("core move not delivered");

  // ************************************************************
  // Write-back and register checks
  // ************************************************************
  // Ops leaving first execute that write straight from the slot
  sequence load_in_ex1;
    st_r.ex1.vld && st_r.ex1.op == `FPD_OP_LOAD && !stall;
  endsequence

  sequence from_core_in_ex1;
    st_r.ex1.vld && st_r.ex1.op == `FPD_OP_FROM_CORE && !stall;
  endsequence

  // Context and hand-off ops leaving first execute
  sequence restore_in_ex1;
    st_r.ex1.vld && st_r.ex1.op == `FPD_OP_RESTORE && !stall;
  endsequence

  sequence to_core_in_ex1;
    st_r.ex1.vld && st_r.ex1.op == `FPD_OP_TO_CORE && !stall;
  endsequence

  // Load result usable by the very next instruction
  load_write_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    load_in_ex1 |=> st_r.res[$past(st_r.ex1.dst)] == $past(st_r.ex1.val))
    else $error("load result not written");

  // Core value lands in its result register
  from_core_write_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    from_core_in_ex1 |=> st_r.res[$past(st_r.ex1.dst)] == $past(st_r.ex1.val))
    else $error("core value not written");

  // Restore brings back results and status together
  restore_copy_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    restore_in_ex1 ##0 !st_r.ex2.vld
      |=> st_r.res == $past(st_r.shd) && st_r.float_status_reg == $past(st_r.stf_shd))
    else $error("restore copy missing");

  // Save also shadows the status word
  save_status_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    (st_r.ex1.vld && st_r.ex1.op == `FPD_OP_SAVE && !stall)
      |=> st_r.stf_shd == $past(st_r.float_status_reg))
    else $error("status shadow missing");

  // Moved-out value is the register before the move
  core_data_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    to_core_in_ex1 |=> o_core_data == $past(st_r.res[st_r.ex1.dst]))
    else $error("core move data wrong");

  // Repeat-block register follows host writes only
  rb_write_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    i_rb_we |=> o_rb == $past(i_rb_wdata))
    else $error("repeat block not written");
  rb_hold_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    !i_rb_we |=> $stable(o_rb))
    else $error("repeat block changed");

  // Status write lands unless a restore overrides it
  stf_write_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    (i_stf_we && !(st_r.ex1.vld && st_r.ex1.op == `FPD_OP_RESTORE && !stall))
      |=> o_stf == $past(i_stf_wdata))
    else $error("status not written");

  // Decode slot frozen during memory waits
  decode_hold_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    stall |=> $stable(st_r.fdec))
    else $error("decode slot moved during wait");

  // Read stage hands on to first execute when free
  read_advance_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    !stall |=> st_r.ex1.vld == $past(st_r.rd.vld))
    else $error("read stage did not advance");

  // Second execute only ever fed by a two-cycle op
  busy_idle_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    !ex1_two |=> !o_ex2_busy)
    else $error("second execute busy without op");

  // Conversions take the second execute stage
  cvt_stage_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    (st_r.ex1.vld && st_r.ex1.op == `FPD_OP_CVT && !stall)
      |=> o_ex2_busy && st_r.ex2.op == `FPD_OP_CVT)
    else $error("conversion skipped second execute");
endmodule

// *** fpd_host_model.sv ***
`timescale 1ns/100ps
// ****************************************
// Host memory bus model
// ****************************************
module fpd_host_model
(
  input wire logic i_clk_sys,
  input wire logic i_rstn,
  input wire logic i_go,
  input wire logic [3:0] i_rw,
  input wire logic [3:0] i_ww,
  input wire logic [31:0] i_pat,
  output logic [31:0] o_rd_data,
  output logic [31:0] o_exec_result,
  output logic o_rd_wait,
  output logic o_wr_wait
);
  logic [3:0] rcnt_r;
  logic [3:0] wcnt_r;
  // Wait-state counters load on request, then count down
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rstn)
    begin
      rcnt_r <= 4'h0;
      wcnt_r <= 4'h0;
    end
    else
    begin
      rcnt_r <= i_go ? i_rw : (o_rd_wait ? rcnt_r - 4'h1 : 4'h0);
      wcnt_r <= i_go ? i_ww : (o_wr_wait ? wcnt_r - 4'h1 : 4'h0);
    end
  end
  // Read data is not valid while the bus waits
  assign o_rd_wait = rcnt_r != 4'h0;
  assign o_wr_wait = wcnt_r != 4'h0;
  assign o_rd_data = o_rd_wait ? ~i_pat : i_pat;
  assign o_exec_result = i_pat ^ 32'h5a5a_5a5a;
endmodule

// *** float_pipeline_delay_slots_tb.sv ***
`timescale 1ns/100ps
`include "fpd_consts.svh"
module float_pipeline_delay_slots_tb;
  import fpd_pkg::*;
  logic clk = 0, rstn = 0, vld = 0, isf = 0, rbwe = 0, stfwe = 0, go = 0, stall, cvld, busy;
  logic [3:0] op = 0, rw = 0, ww = 0;
  logic [2:0] dst = 0, idx = 0;
  logic [31:0] cdat = 0, rbw = 0, stw = 0, pat = 0, rdd, exr, rdv, cout, float_status_reg, rb;
  logic rdw, wrw;
  int error_cnt = 0, checks = 0;
  // ****************************************
  // Clock, design and host model
  // ****************************************
  initial forever #20 clk = ~clk;
  fpd_pipe dut_u (.i_clk_sys(clk), .i_rstn(rstn), .i_d2_vld(vld), .i_d2_is_float(isf),
    .i_d2_op(op), .i_d2_dst(dst), .i_rd_wait(rdw), .i_wr_wait(wrw), .i_rd_data(rdd),
    .i_exec_result(exr), .i_core_data(cdat), .i_rb_we(rbwe), .i_rb_wdata(rbw),
    .i_stf_we(stfwe), .i_stf_wdata(stw), .i_rd_idx(idx), .o_stall(stall), .o_rd_value(rdv),
    .o_core_data(cout), .o_core_vld(cvld), .o_stf(float_status_reg), .o_rb(rb), .o_ex2_busy(busy));
  fpd_host_model host_u (.i_clk_sys(clk), .i_rstn(rstn), .i_go(go), .i_rw(rw), .i_ww(ww),
    .i_pat(pat),
    .o_rd_data(rdd), .o_exec_result(exr), .o_rd_wait(rdw), .o_wr_wait(wrw));
  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic issue(input logic f, input logic [3:0] o, input logic [2:0] d);
    @(negedge clk);
    vld = 1;
    isf = f;
    op = o;
    dst = d;
    @(negedge clk);
    vld = 0;
  endtask
  task automatic rchk(input logic [2:0] i, input logic [31:0] exp);
    idx = i;
    #1;
    cmp(rdv, exp);
  endtask
  task automatic test_done();
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_regs();
    cmp(float_status_reg, 32'h0);
    cmp({31'h0, busy}, 32'h0);
    rbw = 32'h0000_1234;
    stw = 32'h0000_0042;
    rbwe = 1;
    stfwe = 1;
    tick(1);
    rbwe = 0;
    stfwe = 0;
    cmp(rb, 32'h0000_1234);
    cmp(float_status_reg, 32'h0000_0042);
  endtask
  task automatic t_single();
    logic [3:0] ops [4] = '{`FPD_OP_LOAD, `FPD_OP_MINMAX, `FPD_OP_ABSNEG, `FPD_OP_MAC_RPT};
    for (int i = 0; i < 4; i++)
    begin
      pat = 32'h1000_0000 + i;
      issue(1'b1, ops[i], 3'h0);
      tick(3);
      rchk(3'h0, i == 0 ? pat : pat ^ 32'h5a5a_5a5a);
    end
  endtask
  task automatic t_two();
    logic [3:0] ops [5] = '{`FPD_OP_ADD, `FPD_OP_SUB, `FPD_OP_MUL, `FPD_OP_MAC, `FPD_OP_CVT};
    pat = 32'h3f80_0000;
    // Back to back, each next op avoids the previous result register
    for (int i = 0; i < 5; i++)
    begin
      @(negedge clk);
      vld = 1;
      isf = 1;
      op = ops[i];
      dst = 3'(i + 1);
    end
    @(negedge clk);
    vld = 0;
    cmp({31'h0, busy}, 32'h1);
    rchk(3'h1, pat ^ 32'h5a5a_5a5a);
    rchk(3'h2, 32'h0);
    tick(4);
    for (int i = 1; i < 6; i++)
      rchk(3'(i), pat ^ 32'h5a5a_5a5a);
    cmp({31'h0, busy}, 32'h0);
  endtask
  task automatic t_stall();
    for (int k = 0; k < 2; k++)
    begin
      pat = 32'h2000_0000 + k;
      issue(1'b1, `FPD_OP_LOAD, 3'h6);
      rw = k == 0 ? 4'h2 : 4'h0;
      ww = k == 0 ? 4'h0 : 4'h2;
      go = 1;
      tick(1);
      go = 0;
      cmp({31'h0, stall}, 32'h1);
      tick(3);
      rchk(3'h6, k == 0 ? 32'h0 : 32'h2000_0000);
      tick(1);
      rchk(3'h6, pat);
    end
  endtask
  task automatic t_core();
    cdat = 32'h0cde_1234;
    issue(1'b0, `FPD_OP_LOAD, 3'h7);
    tick(4);
    rchk(3'h7, 32'h0);
    issue(1'b1, `FPD_OP_FROM_CORE, 3'h7);
    tick(4);
    rchk(3'h7, cdat);
    issue(1'b1, `FPD_OP_TO_CORE, 3'h7);
    tick(2);
    cmp({31'h0, cvld}, 32'h0);
    tick(1);
    cmp({31'h0, cvld}, 32'h1);
    cmp(cout, cdat);
    tick(1);
    cmp({31'h0, cvld}, 32'h0);
  endtask
  task automatic t_shadow();
    pat = 32'h4000_0001;
    issue(1'b1, `FPD_OP_LOAD, 3'h0);
    tick(3);
    issue(1'b1, `FPD_OP_SAVE, 3'h0);
    tick(4);
    pat = 32'h4000_0002;
    issue(1'b1, `FPD_OP_LOAD, 3'h0);
    stw = 32'h0000_0099;
    stfwe = 1;
    tick(1);
    stfwe = 0;
    tick(2);
    rchk(3'h0, 32'h4000_0002);
    cmp(float_status_reg, 32'h0000_0099);
    issue(1'b1, `FPD_OP_RESTORE, 3'h0);
    tick(4);
    rchk(3'h0, 32'h4000_0001);
    cmp(float_status_reg, 32'h0000_0042);
  endtask
  // ****************************************
  // Main sequence and watchdog
  // ****************************************
  initial
  begin
    tick(8);
    rstn = 1;
    t_regs();
    t_single();
    t_two();
    t_stall();
    t_core();
    t_shadow();
    test_done();
  end
  initial
  begin
    #400000;
    error_cnt++;
    test_done();
  end
endmodule
